/* File: core/lvd_pkg.sv */
// package for the low voltage detect block: register map, fields, reset values
// assumes a 32-bit apb slave with byte addresses, one register per word
package lvd_pkg;
    // register byte offsets
    localparam logic [7:0] LVD_OFS_CTRL = 8'h00;
    localparam logic [7:0] LVD_OFS_FLAGS = 8'h04;
    localparam logic [7:0] LVD_OFS_ENABLES = 8'h08;
    localparam logic [7:0] LVD_OFS_PRIO = 8'h0C;
    localparam logic [7:0] LVD_OFS_GLOBAL = 8'h10;
    // control field positions
    localparam int LVD_SEL_LSB = 0;
    localparam int LVD_SEL_W = 4;
    localparam int LVD_EN_BIT = 4;
    localparam int LVD_STABLE_BIT = 5;
    // flag/enable/priority position of the low-voltage source
    localparam int LVD_FLAG_BIT = 2;
    // writable bits of the peripheral group 2 registers
    localparam logic [7:0] LVD_GRP2_MASK = 8'h0F;
    // reset values
    localparam logic [3:0] LVD_SEL_RST = 4'h5;
    localparam logic [7:0] LVD_GRP2_RST = 8'h00;
    // select code routing the external input
    localparam logic [3:0] LVD_SEL_EXT = 4'hF;
    // reference settle time and its cycle count at pclk rate
    localparam int LVD_CLK_HZ = 20_000_000;
    localparam int LVD_SETTLE_US = 50;
    localparam int LVD_SETTLE_CYC = (LVD_SETTLE_US * (LVD_CLK_HZ / 1_000_000));
    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lvd_apb_req_t;
    // analog front end observation
    typedef struct packed {
        logic below_trip;
        logic ref_ready;
    } lvd_ana_t;
endpackage

/* File: core/lvd_sync.sv */
// two-flop level synchroniser
// assumes an asynchronous input with no required phase relation to clk
`timescale 1ns/1ps
module lvd_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic d,
    output logic q
);
    logic meta_r;
    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // lvd_sync

/* File: core/lvd_settle.sv */
// settle timer: counts a fixed time after enable before stable is reported
// assumes clk is a free-running clock whose rate was used to size COUNT
`timescale 1ns/1ps
module lvd_settle #(
    parameter int COUNT = 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control and result
    input wire logic enable,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_r;
    // restart on every disable so each enable waits the full time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (!enable) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (cnt_r == W'(COUNT - 1)) begin
            done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end
endmodule // lvd_settle

/* File: core/lvd_top.sv */
// low voltage detect control and status logic behind an apb slave
// assumes the analog divider, reference and comparator sit outside as inputs
`timescale 1ns/1ps
// Overview of operation
// - comparator below trip sets low-voltage flag
// - four-bit trip point select field
// - select all ones routes external input
// - lower codes select lower internal thresholds
// - bit four powers comparator up or down
// - bit five reads reference stable, read-only
// - bits seven and six read zero
// - reset control value is select 0101
// - any reset restores registers, detector off
// - no flag until reference is stable
// - works in sleep, crossing wakes device
// - flag and enables together request interrupt
// - settle timed by a pclk cycle count, plus reference ready
module lvd_top #(
    parameter int SETTLE_CYC = lvd_pkg::LVD_SETTLE_CYC
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic cmp_below_async,
    input wire logic ref_ready_async,
    input wire logic sleep_mode,
    output logic [3:0] trip_point_select,
    output logic ext_input_route,
    output logic detector_power_enable,
    // interrupt, wake
    output logic irq,
    output logic irq_high_prio,
    output logic wake_req
);
    import lvd_pkg::*;

    lvd_apb_req_t req;
    lvd_ana_t ana;
    logic [3:0] sel_r;
    logic en_r;
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic [7:0] prio_r;
    logic global_en_r;
    logic below_s;
    logic ref_s;
    logic settled;
    logic stable;
    logic below_d_r;
    logic set_ev;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic [31:0] rd_mux;
    logic flag_wr;
    logic irq_nxt;
    logic wr_ctrl;
    logic wr_enables;
    logic wr_prio;
    logic wr_global;
    logic wake_src;

    // detector phase: powered off, waiting on the reference, or armed
    typedef enum logic [1:0] {PH_OFF, PH_SETTLE, PH_ARMED} lvd_phase_t;
    lvd_phase_t phase_r;
    lvd_phase_t phase_nxt;

    // gather the bus into one bundle
    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};
    assign wr_acc = req.psel && req.penable && req.pwrite;
    assign rd_acc = req.psel && !req.penable && !req.pwrite;
    assign hit = (req.paddr == LVD_OFS_CTRL) || (req.paddr == LVD_OFS_FLAGS) ||
                 (req.paddr == LVD_OFS_ENABLES) || (req.paddr == LVD_OFS_PRIO) ||
                 (req.paddr == LVD_OFS_GLOBAL);
    assign flag_wr = wr_acc && (req.paddr == LVD_OFS_FLAGS);
    // one write strobe per register keeps each register block short
    assign wr_ctrl = wr_acc && (req.paddr == LVD_OFS_CTRL);
    assign wr_enables = wr_acc && (req.paddr == LVD_OFS_ENABLES);
    assign wr_prio = wr_acc && (req.paddr == LVD_OFS_PRIO);
    assign wr_global = wr_acc && (req.paddr == LVD_OFS_GLOBAL);

    // bring the analog levels into pclk
    lvd_sync u_sync_cmp (
        .clk(pclk),
        .rst_n(presetn),
        .d(cmp_below_async),
        .q(below_s)
    );
    lvd_sync u_sync_ref (
        .clk(pclk),
        .rst_n(presetn),
        .d(ref_ready_async),
        .q(ref_s)
    );
    assign ana = '{below_trip: below_s, ref_ready: ref_s};

    // fixed-time wait; the analog ready must also agree, so a slow part is covered
    lvd_settle #(
        .COUNT(SETTLE_CYC)
    ) u_settle (
        .clk(pclk),
        .rst_n(presetn),
        .enable(en_r),
        .done(settled)
    );
    // phase walk; the timer and the analog ready must both agree before arming,
    // and a reference that drops out sends the detector back to waiting
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            PH_OFF: begin
                if (en_r) begin
                    phase_nxt = PH_SETTLE;
                end
            end
            PH_SETTLE: begin
                if (!en_r) begin
                    phase_nxt = PH_OFF;
                end else if (settled && ana.ref_ready) begin
                    phase_nxt = PH_ARMED;
                end
            end
            PH_ARMED: begin
                if (!en_r) begin
                    phase_nxt = PH_OFF;
                end else if (!ana.ref_ready) begin
                    phase_nxt = PH_SETTLE;
                end
            end
            default: phase_nxt = PH_OFF;
        endcase
    end

    // phase register; any reset leaves the detector off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= PH_OFF;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // enable and ready gate the armed phase at once, so a disable is never late
    assign stable = (phase_r == PH_ARMED) && ana.ref_ready && en_r;

    // rising crossing of the trip point, only once stable
    assign set_ev = stable && ana.below_trip && !below_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_d_r <= 1'b0;
        end else begin
            below_d_r <= ana.below_trip && stable;
        end
    end

    // trip point select; the code reaches the divider one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= LVD_SEL_RST;
        end else if (wr_ctrl) begin
            sel_r <= req.pwdata[LVD_SEL_LSB +: LVD_SEL_W];
        end
    end

    // power enable; clearing it also restarts the settle wait,
    // so a quick off and on never skips the reference start-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
        end else if (wr_ctrl) begin
            en_r <= req.pwdata[LVD_EN_BIT];
        end
    end

    // flag register: hardware set beats a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= LVD_GRP2_RST;
        end else begin
            if (flag_wr) begin
                flags_r <= req.pwdata[7:0] & LVD_GRP2_MASK;
            end
            if (set_ev) begin
                flags_r[LVD_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // interrupt enable register; the low-voltage source sits in bit 2,
    // and it also lets a pending flag wake a sleeping core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_r <= LVD_GRP2_RST;
        end else if (wr_enables) begin
            enables_r <= req.pwdata[7:0] & LVD_GRP2_MASK;
        end
    end

    // priority register; only decides whether the high-priority line also carries the irq
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_r <= LVD_GRP2_RST;
        end else if (wr_prio) begin
            prio_r <= req.pwdata[7:0] & LVD_GRP2_MASK;
        end
    end

    // global enable; gates the irq but not the wake,
    // since a sleeping core must still come back on a crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_en_r <= 1'b0;
        end else if (wr_global) begin
            global_en_r <= req.pwdata[0];
        end
    end

    // read mux; unimplemented bits return zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (req.paddr)
            LVD_OFS_CTRL: begin
                rd_mux[LVD_SEL_LSB +: LVD_SEL_W] = sel_r;
                rd_mux[LVD_EN_BIT] = en_r;
                rd_mux[LVD_STABLE_BIT] = stable;
            end
            LVD_OFS_FLAGS: rd_mux[7:0] = flags_r;
            LVD_OFS_ENABLES: rd_mux[7:0] = enables_r;
            LVD_OFS_PRIO: rd_mux[7:0] = prio_r;
            LVD_OFS_GLOBAL: rd_mux[0] = global_en_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in setup so it stands through the access phase;
    // a live stable bit may move later, the captured word does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata <= rd_mux;
        end
    end

    // no wait state: ready follows every setup cycle for exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= req.psel && !req.penable;
        end
    end

    // unmapped addresses are refused alongside ready; their writes never decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= req.psel && !req.penable && !hit;
        end
    end

    // interrupt request from flag with both enables
    assign irq_nxt = flags_r[LVD_FLAG_BIT] && enables_r[LVD_FLAG_BIT] && global_en_r;

    // level irq, one register stage behind the flag and enables;
    // it drops only when software clears the flag or a mask bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

    // high-priority copy, never without the plain request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high_prio <= 1'b0;
        end else begin
            irq_high_prio <= irq_nxt && prio_r[LVD_FLAG_BIT];
        end
    end

    // fresh crossing, or a pending enabled flag left over from before sleep
    assign wake_src = set_ev || (flags_r[LVD_FLAG_BIT] && enables_r[LVD_FLAG_BIT]);

    // wake needs no global enable; clock may be slow in sleep, so flagged
    // crossing wakes on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= sleep_mode && en_r && wake_src;
        end
    end

    // divider tap select, registered so the analog side sees no glitches;
    // higher codes pick higher thresholds, decoded in the divider itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_point_select <= LVD_SEL_RST;
        end else begin
            trip_point_select <= sel_r;
        end
    end

    // external input route; moves in the same cycle as the tap select,
    // so the comparator never sees a mixed setting for more than an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_input_route <= 1'b0;
        end else begin
            ext_input_route <= (sel_r == LVD_SEL_EXT);
        end
    end

    // analog power enable, a registered copy of the control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detector_power_enable <= 1'b0;
        end else begin
            detector_power_enable <= en_r;
        end
    end
endmodule // lvd_top

/* File: testbench/lvd_assertions.sv */
// port checker for lvd_top
// assumes one pclk domain, bound into every lvd_top
`timescale 1ns/1ps
module lvd_chk (
    // clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // front end, irq
    input wire logic sleep_mode,
    input wire logic [3:0] trip_point_select,
    input wire logic ext_input_route,
    input wire logic detector_power_enable,
    input wire logic irq,
    input wire logic irq_high_prio,
    input wire logic wake_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ext_route: assert property (ext_input_route == (trip_point_select == 4'hF))
        else $error("route disagrees with select");
    chk_ctrl_write: assert property (psel && penable && pready && pwrite && paddr == 8'h00
        |-> ##2 trip_point_select == $past(pwdata[3:0], 2)
        && detector_power_enable == $past(pwdata[4], 2))
        else $error("ctrl write not applied");
    chk_reset_val: assert property ($rose(presetn) |-> trip_point_select == 4'h5
        && !detector_power_enable && !irq && !wake_req)
        else $error("bad value after reset");
    chk_prio_irq: assert property (irq_high_prio |-> irq)
        else $error("priority irq without irq");
    chk_wake_sleep: assert property (wake_req |-> $past(sleep_mode)
        && detector_power_enable)
        else $error("wake outside enabled sleep");
    // access phase lasts one cycle after setup
    chk_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_unmapped_err: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
        else $error("unmapped access not refused");
endmodule // lvd_chk
bind lvd_top lvd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .trip_point_select(trip_point_select),
    .ext_input_route(ext_input_route), .detector_power_enable(detector_power_enable),
    .irq(irq), .irq_high_prio(irq_high_prio), .wake_req(wake_req));

/* File: testbench/low_voltage_detect_control_test.sv */
// self-checking bench for lvd_top with a register model
// assumes lvd_pkg map; settle count shortened to keep the run brief
`timescale 1ns/1ps
module low_voltage_detect_control_test;
    import lvd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, se, cmp = 0, refr = 0, slp = 0, ext, pen, irq, hp, wk;
    logic [3:0] tps;
    int err_count = 0, n_checks = 0, cyc = 0, seed = 99634, stb = 0, m[8];
    always #25 pclk = ~pclk;
    lvd_top #(.SETTLE_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_below_async(cmp), .ref_ready_async(refr),
        .sleep_mode(slp), .trip_point_select(tps), .ext_input_route(ext),
        .detector_power_enable(pen), .irq(irq), .irq_high_prio(hp), .wake_req(wk));
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one transfer; values read at the edge that samples pready
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && a <= 8'h10) m[a[4:2]] = d & ((a == 0) ? 'h1F : (a == 8'h10) ? 1 : 'hF);
    endtask
    // read compared with the model; stable bit kept apart
    task automatic rd(logic [7:0] a, string nm);
        apb(0, a, 0);
        chk(nm, (a == 0) ? m[0] | (stb << 5) : m[a[4:2]], q);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        int r;
        m = '{0, 0, 0, 0, 0, 0, 0, 0};
        m[0] = 5;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int a = 0; a <= 20; a += 4) rd(8'(a), "reset");
        chk("slverr", 1, 32'(se));
        // all select codes, junk in the upper bits must read zero
        for (int s = 0; s < 16; s++) begin
            r = $random(seed);
            apb(1, 8'h00, {24'h0, r[7:5], 1'b0, 4'(s)});
            rd(8'h00, "sel");
            chk("route", 32'(s == 15), 32'(ext));
            chk("tps", 32'(s), 32'(tps));
        end
        // enabled but reference not ready: no flag
        apb(1, 8'h00, 32'h13);
        cmp <= 1;
        repeat (20) @(posedge pclk);
        rd(8'h00, "unstable");
        chk("pen", 1, 32'(pen));
        rd(8'h04, "early flag");
        refr <= 1;
        cmp <= 0;
        stb = 1;
        repeat (20) @(posedge pclk);
        rd(8'h00, "stable");
        apb(1, 8'h04, 0);
        apb(1, 8'h08, 4);
        apb(1, 8'h10, 1);
        cmp <= 1;
        m[1] = 4;
        repeat (10) @(posedge pclk);
        rd(8'h04, "flag");
        chk("irq", 1, 32'(irq));
        cmp <= 0;
        apb(1, 8'h0C, 4);
        repeat (10) @(posedge pclk);
        rd(8'h04, "sticky");
        chk("prio", 1, 32'(hp));
        apb(1, 8'h08, 0);
        rd(8'h08, "mask");
        chk("masked", 0, 32'(irq));
        apb(1, 8'h04, 0);
        rd(8'h04, "flag clr");
        // crossing while asleep wakes the core
        slp <= 1;
        apb(1, 8'h08, 4);
        cmp <= 1;
        m[1] = 4;
        r = 0;
        while (wk !== 1'b1 && r < 20) begin
            @(posedge pclk);
            r++;
        end
        chk("wake", 1, 32'(wk));
        rd(8'h04, "sleep flag");
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        slp <= 0;
        m = '{5, 0, 0, 0, 0, 0, 0, 0};
        stb = 0;
        rd(8'h00, "ctrl rst2");
        chk("pen off", 0, 32'(pen));
        rd(8'h04, "flag rst2");
        give_verdict();
    end
endmodule // low_voltage_detect_control_test
